// ---- pbd_diag.sv ----
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Saved receive head pointer, 13 bits, resets to zero, restores live head.
// - Saved receive tail pointer, 13 bits, resets to zero, restores live tail.
// - Upper bits 31:13 of pointer and count registers read as zero.
// - Report number of received packets held in receive FIFO, 13 bits.
// - Report number of packets awaiting transmit in transmit FIFO, 13 bits.
// - Transmit pointers and saved copies reset to allocation times 128.
// - Pointers count eight-byte units; value eight means byte 64.
// - Transmit pointers are offsets from start of whole buffer.
// - Transmit head pointer also decoded at alias 0x08010.
// - Transmit tail pointer also decoded at alias 0x08018.
// - Saved transmit head pointer, 13 bits, restores live head.
// - Saved transmit tail pointer, 13 bits, restores live tail.
// - Buffer readable and writable through window 0x10000-0x19FFF up to the active size.
// - Buffer holds 40 KB, default split 12 KB receive, 28 KB transmit.
// - Receive region sits first in the window.
// - Size register keeps six writable bits in 1 KB steps, default 0x28.
// - Transmit/receive split follows allocation field, not size register.
// - New size takes effect only at global device reset.
// - Size register survives global reset, set back to 0x28 only at power-on.
// - Live receive head pointer is offset from start of whole buffer.
module pbd_diag
   import pbd_pkg::*;
(
   // Clock and power-on reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Global device reset and allocation
   input wire logic dev_reset,
   input wire logic [SIZE_W-1:0] receive_allocation_field,
   // Packet events from the data paths
   input wire pbd_pkt_evt_t pkt_evt,
   // State towards the data paths
   output logic [PTR_W-1:0] tx_head_pointer,
   output logic [PTR_W-1:0] tx_tail_pointer,
   output logic [SIZE_W-1:0] buffer_size_active,
   output logic [63:0] tx_head_data
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic init_q;
   logic [SIZE_W-1:0] size_q;
   logic [SIZE_W-1:0] eff_q;
   logic [PTR_W-1:0] rx_hs_q, rx_ts_q, rx_cnt_q, tx_cnt_q;
   logic [PTR_W-1:0] tx_h_q, tx_t_q, tx_hs_q, tx_ts_q;
   logic [63:0] tx_data_q;
   logic [63:0] mem [MEM_QWORDS];

   // Decode results
   pbd_sel_t sel;
   logic [ADDR_W-1:0] win_off;
   logic [15:0] eff_bytes;
   logic [MEM_IDX_W-1:0] mem_idx;
   logic [31:0] reg_rdata;
   logic access, wr_done, load_tx;
   logic [PTR_W-1:0] tx_init;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   assign access = psel && penable;
   assign wr_done = access && pready_q && pwrite && !pslverr_q;
   assign win_off = paddr - WIN_BASE;
   assign mem_idx = win_off[MEM_IDX_W+QWORD_SHIFT-1:QWORD_SHIFT];
   assign eff_bytes = {eff_q, 10'h000};
   assign tx_init = {receive_allocation_field, 7'h00};
   assign load_tx = init_q || dev_reset;

   // Map the address onto one register or the buffer window
   always_comb begin
      sel = SEL_NONE;
      case (paddr)
         OFF_BUF_SIZE: sel = SEL_SIZE;
         OFF_RX_HEAD_SAVED: sel = SEL_RXHS;
         OFF_RX_TAIL_SAVED: sel = SEL_RXTS;
         OFF_RX_PKT_COUNT: sel = SEL_RXPC;
         OFF_TX_HEAD, OFF_TX_HEAD_ALIAS: sel = SEL_TXH;
         OFF_TX_TAIL, OFF_TX_TAIL_ALIAS: sel = SEL_TXT;
         OFF_TX_HEAD_SAVED: sel = SEL_TXHS;
         OFF_TX_TAIL_SAVED: sel = SEL_TXTS;
         OFF_TX_PKT_COUNT: sel = SEL_TXPC;
         default: begin
            // Window limited to the size active since the last reset
            if (paddr >= WIN_BASE && paddr <= WIN_LAST &&
                paddr[1:0] == 2'b00 &&
                win_off[15:0] < eff_bytes) begin
               sel = SEL_WIN;
            end
         end
      endcase
   end

   // Register read mux, unused upper bits forced low
   always_comb begin
      reg_rdata = 32'h0000_0000;
      case (sel)
         SEL_SIZE: reg_rdata[SIZE_W-1:0] = size_q;
         SEL_RXHS: reg_rdata[PTR_W-1:0] = rx_hs_q;
         SEL_RXTS: reg_rdata[PTR_W-1:0] = rx_ts_q;
         SEL_RXPC: reg_rdata[PTR_W-1:0] = rx_cnt_q;
         SEL_TXH: reg_rdata[PTR_W-1:0] = tx_h_q;
         SEL_TXT: reg_rdata[PTR_W-1:0] = tx_t_q;
         SEL_TXHS: reg_rdata[PTR_W-1:0] = tx_hs_q;
         SEL_TXTS: reg_rdata[PTR_W-1:0] = tx_ts_q;
         SEL_TXPC: reg_rdata[PTR_W-1:0] = tx_cnt_q;
         default: reg_rdata = 32'h0000_0000;
      endcase
   end

   // Byte-lane merge of a 13-bit field; upper bits are dropped
   function automatic logic [PTR_W-1:0] merge_ptr(
      input logic [PTR_W-1:0] old,
      input logic [31:0] wd,
      input logic [3:0] st
   );
      logic [PTR_W-1:0] r;
      r = old;
      if (st[0]) begin
         r[7:0] = wd[7:0];
      end
      if (st[1]) begin
         r[12:8] = wd[12:8];
      end
      return r;
   endfunction : merge_ptr

   // ----------------------------------------------------------------------
   // APB handshake: one wait state on every access
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= access && !pready_q;
         pslverr_q <= access && !pready_q && (sel == SEL_NONE);
      end
   end

   // Read data captured in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (access && !pready_q && !pwrite) begin
         if (sel == SEL_WIN) begin
            prdata_q <= paddr[2] ? mem[mem_idx][63:32] :
                                   mem[mem_idx][31:0];
         end else begin
            prdata_q <= reg_rdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Packet buffer memory, 64-bit words, 32-bit lanes by address bit 2
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk) begin
      if (wr_done && sel == SEL_WIN) begin
         for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
               mem[mem_idx][{paddr[2], 5'h00} + 6'(b * 8) +: 8] <=
                  pwdata[b*8 +: 8];
            end
         end
      end
   end

   // Quadword at the transmit head, pointer taken as buffer offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data_q <= 64'h0;
      end else if (tx_h_q < MEM_IDX_W'(MEM_QWORDS)) begin
         tx_data_q <= mem[tx_h_q];
      end else begin
         tx_data_q <= 64'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Buffer size: only power-on resets it to 0x28, device reset applies it
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_q <= BUF_SIZE_RST;
      end else if (wr_done && sel == SEL_SIZE && pstrb[0]) begin
         size_q <= pwdata[SIZE_W-1:0];
      end
   end

   // Size in force for the window, updated at device reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_q <= BUF_SIZE_RST;
      end else if (dev_reset) begin
         eff_q <= size_q;
      end
   end

   // Init pulse in the first cycle after power-on release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_q <= 1'b1;
      end else begin
         init_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Receive saved pointers
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_hs_q <= RX_PTR_RST;
         rx_ts_q <= RX_PTR_RST;
      end else if (dev_reset) begin
         rx_hs_q <= RX_PTR_RST;
         rx_ts_q <= RX_PTR_RST;
      end else if (wr_done) begin
         if (sel == SEL_RXHS) begin
            rx_hs_q <= merge_ptr(rx_hs_q, pwdata, pstrb);
         end
         if (sel == SEL_RXTS) begin
            rx_ts_q <= merge_ptr(rx_ts_q, pwdata, pstrb);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Transmit pointers and saved copies
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_h_q <= TX_PTR_RST;
         tx_t_q <= TX_PTR_RST;
         tx_hs_q <= TX_PTR_RST;
         tx_ts_q <= TX_PTR_RST;
      end else if (load_tx) begin
         tx_h_q <= tx_init;
         tx_t_q <= tx_init;
         tx_hs_q <= tx_init;
         tx_ts_q <= tx_init;
      end else if (wr_done) begin
         if (sel == SEL_TXH) begin
            tx_h_q <= merge_ptr(tx_h_q, pwdata, pstrb);
         end
         if (sel == SEL_TXT) begin
            tx_t_q <= merge_ptr(tx_t_q, pwdata, pstrb);
         end
         if (sel == SEL_TXHS) begin
            tx_hs_q <= merge_ptr(tx_hs_q, pwdata, pstrb);
         end
         if (sel == SEL_TXTS) begin
            tx_ts_q <= merge_ptr(tx_ts_q, pwdata, pstrb);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Packet counts: a diagnostic write overrides that cycle's events
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cnt_q <= PKT_COUNT_RST;
      end else if (dev_reset) begin
         rx_cnt_q <= PKT_COUNT_RST;
      end else if (wr_done && sel == SEL_RXPC) begin
         rx_cnt_q <= merge_ptr(rx_cnt_q, pwdata, pstrb);
      end else if (pkt_evt.rx_inc != pkt_evt.rx_dec) begin
         rx_cnt_q <= pkt_evt.rx_inc ? PTR_W'(rx_cnt_q + 13'd1) :
                                      PTR_W'(rx_cnt_q - 13'd1);
      end
   end

   // Transmit packet count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt_q <= PKT_COUNT_RST;
      end else if (dev_reset) begin
         tx_cnt_q <= PKT_COUNT_RST;
      end else if (wr_done && sel == SEL_TXPC) begin
         tx_cnt_q <= merge_ptr(tx_cnt_q, pwdata, pstrb);
      end else if (pkt_evt.tx_inc != pkt_evt.tx_dec) begin
         tx_cnt_q <= pkt_evt.tx_inc ? PTR_W'(tx_cnt_q + 13'd1) :
                                      PTR_W'(tx_cnt_q - 13'd1);
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
   assign tx_head_pointer = tx_h_q;
   assign tx_tail_pointer = tx_t_q;
   assign buffer_size_active = eff_q;
   assign tx_head_data = tx_data_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_first_access;
      psel && penable && !pready_q;
   endsequence

   a_ready_timing: assert property (
      s_setup ##1 s_first_access |=> pready_q)
      else $error("pready not high in second access cycle");

   a_ptr_upper_zero: assert property (
      s_first_access and (!pwrite && sel != SEL_WIN && sel != SEL_SIZE)
      |=> prdata_q[31:13] == 19'h0)
      else $error("pointer read shows upper bits set");

   a_size_upper_zero: assert property (
      s_first_access and (!pwrite && sel == SEL_SIZE)
      |=> prdata_q[31:6] == 26'h0 && prdata_q[5:0] == $past(size_q))
      else $error("size read wrong");

   a_tx_reset_load: assert property (
      dev_reset |=> tx_h_q == {$past(receive_allocation_field), 7'h00}
                    && tx_ts_q == tx_h_q)
      else $error("transmit pointers not loaded from allocation");

   a_size_kept: assert property (
      dev_reset && !wr_done |=> size_q == $past(size_q))
      else $error("size register changed by device reset");

   a_eff_applied: assert property (
      dev_reset |=> eff_q == $past(size_q))
      else $error("active size not taken at device reset");

   a_eff_held: assert property (
      !dev_reset |=> eff_q == $past(eff_q))
      else $error("active size changed without device reset");

   a_alias_head: assert property (
      wr_done && paddr == OFF_TX_HEAD_ALIAS && pstrb[1:0] == 2'b11 &&
      !load_tx |=> tx_h_q == $past(pwdata[12:0]))
      else $error("alias write missed transmit head");

   a_alias_tail: assert property (
      wr_done && paddr == OFF_TX_TAIL_ALIAS && pstrb[1:0] == 2'b11 &&
      !load_tx |=> tx_t_q == $past(pwdata[12:0]))
      else $error("alias write missed transmit tail");

   a_rx_count_up: assert property (
      pkt_evt.rx_inc && !pkt_evt.rx_dec && !dev_reset &&
      !(wr_done && sel == SEL_RXPC)
      |=> rx_cnt_q == PTR_W'($past(rx_cnt_q) + 13'd1))
      else $error("receive count did not advance");

   a_win_limit: assert property (
      s_first_access and (paddr >= WIN_BASE && paddr <= WIN_LAST &&
      win_off[15:0] >= eff_bytes) |=> pslverr_q)
      else $error("access past active size not refused");

endmodule : pbd_diag

`default_nettype wire

// ---- pbd_pkg.sv ----
package pbd_pkg;

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int PTR_W = 13;
   localparam int SIZE_W = 6;
   localparam int ADDR_W = 20;
   localparam int MEM_QWORDS = 5120;
   localparam int MEM_IDX_W = 13;

   // ----------------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_BUF_SIZE = 20'h01008;
   localparam logic [ADDR_W-1:0] OFF_RX_HEAD_SAVED = 20'h02420;
   localparam logic [ADDR_W-1:0] OFF_RX_TAIL_SAVED = 20'h02428;
   localparam logic [ADDR_W-1:0] OFF_RX_PKT_COUNT = 20'h02430;
   localparam logic [ADDR_W-1:0] OFF_TX_HEAD = 20'h03410;
   localparam logic [ADDR_W-1:0] OFF_TX_TAIL = 20'h03418;
   localparam logic [ADDR_W-1:0] OFF_TX_HEAD_SAVED = 20'h03420;
   localparam logic [ADDR_W-1:0] OFF_TX_TAIL_SAVED = 20'h03428;
   localparam logic [ADDR_W-1:0] OFF_TX_PKT_COUNT = 20'h03430;
   localparam logic [ADDR_W-1:0] OFF_TX_HEAD_ALIAS = 20'h08010;
   localparam logic [ADDR_W-1:0] OFF_TX_TAIL_ALIAS = 20'h08018;
   localparam logic [ADDR_W-1:0] WIN_BASE = 20'h10000;
   localparam logic [ADDR_W-1:0] WIN_LAST = 20'h19fff;

   // ----------------------------------------------------------------------
   // Values after reset and scaling
   // ----------------------------------------------------------------------
   localparam logic [SIZE_W-1:0] BUF_SIZE_RST = 6'h28;
   localparam logic [PTR_W-1:0] TX_PTR_RST = 13'h0600;
   localparam logic [PTR_W-1:0] RX_PTR_RST = 13'h0000;
   localparam logic [PTR_W-1:0] PKT_COUNT_RST = 13'h0000;
   localparam int ALLOC_SHIFT = 7;
   localparam int KB_SHIFT = 10;
   localparam int QWORD_SHIFT = 3;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic rx_inc;
      logic rx_dec;
      logic tx_inc;
      logic tx_dec;
   } pbd_pkt_evt_t;

   typedef enum logic [3:0] {
      SEL_NONE, SEL_SIZE, SEL_RXHS, SEL_RXTS, SEL_RXPC, SEL_TXH,
      SEL_TXT, SEL_TXHS, SEL_TXTS, SEL_TXPC, SEL_WIN
   } pbd_sel_t;

endpackage : pbd_pkg

// ---- tb.sv ----
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// Testbench for the packet buffer diagnostic block
// ---------------------------------------------------------------
module tb;
   import pbd_pkg::*;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dev_reset;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, v, lo, hi;
   logic [3:0] pstrb, strb;
   logic [SIZE_W-1:0] receive_allocation_field, buffer_size_active;
   pbd_pkt_evt_t pkt_evt;
   logic [PTR_W-1:0] tx_head_pointer, tx_tail_pointer, q;
   logic [63:0] tx_head_data;
   logic [ADDR_W-1:0] regs [8];
   logic [ADDR_W-1:0] wins [4];
   logic [31:0] win_v [4];
   logic e;
   int errors, samples_checked, seed, nr, nt;

   pbd_diag dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .dev_reset(dev_reset),
      .receive_allocation_field(receive_allocation_field),
      .pkt_evt(pkt_evt), .tx_head_pointer(tx_head_pointer),
      .tx_tail_pointer(tx_tail_pointer),
      .buffer_size_active(buffer_size_active), .tx_head_data(tx_head_data)
   );

   // Clock of 50 ns period
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      wrap_up();
   end

   // ---------------------------------------------------------------
   // Expectations and helpers
   // ---------------------------------------------------------------
   function automatic logic [PTR_W-1:0] tx_init(input logic [5:0] a);
      return PTR_W'(a) * 13'h0080; // Allocation in 128-qword units
   endfunction : tx_init

   function automatic logic [31:0] rst_val(input int i, input logic [5:0] a);
      return (i >= 3 && i <= 6) ? 32'(tx_init(a)) : 32'h0;
   endfunction : rst_val

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task wrap_up;
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   // One APB transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [19:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= strb;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold until pready is seen high at a rising edge; watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic err;
      apb(1'b1, a, d, r, err);
   endtask : wr

   task automatic rdchk(input logic [19:0] a, input logic ee,
                        input logic [31:0] ed);
      logic [31:0] r;
      logic err;
      apb(1'b0, a, 32'h0, r, err);
      chk({31'h0, err, r}, {31'h0, ee, ed});
   endtask : rdchk

   // Packet event held for n sampling edges
   task automatic evt(input logic [3:0] ev, input int n);
      @(posedge pclk);
      pkt_evt <= pbd_pkt_evt_t'(ev);
      repeat (n) @(posedge pclk);
      pkt_evt <= '0;
   endtask : evt

   task por;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask : por

   task devrst(input logic [5:0] a);
      @(posedge pclk);
      dev_reset <= 1'b1;
      receive_allocation_field <= a;
      @(posedge pclk);
      dev_reset <= 1'b0;
      @(negedge pclk);
   endtask : devrst

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 24;
      errors = 0;
      samples_checked = 0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      strb = 4'hf;
      dev_reset = 1'b0;
      receive_allocation_field = 6'h0c;
      pkt_evt = '0;
      presetn = 1'b0;
      regs = '{OFF_RX_HEAD_SAVED, OFF_RX_TAIL_SAVED, OFF_RX_PKT_COUNT,
               OFF_TX_HEAD, OFF_TX_TAIL, OFF_TX_HEAD_SAVED,
               OFF_TX_TAIL_SAVED, OFF_TX_PKT_COUNT};
      wins = '{WIN_BASE, 20'h14ffc, 20'h15000, 20'h19ffc};
      por();
      // Values after power-on
      chk(64'(tx_head_pointer), 64'h600);
      chk(64'(buffer_size_active), 64'h28);
      rdchk(OFF_BUF_SIZE, 1'b0, 32'h28);
      foreach (regs[i]) rdchk(regs[i], 1'b0, rst_val(i, 6'h0c));
      // Random writes with upper bits set read back 13 bits
      foreach (regs[i]) begin
         v = $random(seed) | 32'h8000_0000;
         wr(regs[i], v);
         rdchk(regs[i], 1'b0, v & 32'h1fff);
      end
      // Compatibility aliases
      v = $random(seed);
      wr(OFF_TX_HEAD_ALIAS, v);
      rdchk(OFF_TX_HEAD, 1'b0, v & 32'h1fff);
      @(negedge pclk);
      chk(64'(tx_head_pointer), 64'(v[12:0]));
      v = $random(seed);
      wr(OFF_TX_TAIL_ALIAS, v);
      rdchk(OFF_TX_TAIL_ALIAS, 1'b0, v & 32'h1fff);
      @(negedge pclk);
      chk(64'(tx_tail_pointer), 64'(v[12:0]));
      // Byte strobes: lane 0 holds bits 7:0, lane 1 holds bits 12:8
      wr(OFF_TX_HEAD_SAVED, 32'h0000_0a5c);
      strb = 4'h2;
      wr(OFF_TX_HEAD_SAVED, 32'hffff_ffff);
      strb = 4'h1;
      wr(OFF_BUF_SIZE, 32'h0000_0011);
      strb = 4'h2;
      wr(OFF_BUF_SIZE, 32'h0000_003f);
      strb = 4'hf;
      rdchk(OFF_TX_HEAD_SAVED, 1'b0, 32'h1f5c);
      rdchk(OFF_BUF_SIZE, 1'b0, 32'h11);
      // Unmapped and unaligned places are refused
      wr(20'h02410, 32'h1234);
      rdchk(20'h02410, 1'b1, 32'h0);
      rdchk(20'h02422, 1'b1, 32'h0);
      // Packet counts
      wr(OFF_RX_PKT_COUNT, 32'h0);
      wr(OFF_TX_PKT_COUNT, 32'h0);
      nr = 1 + ($random(seed) & 15);
      nt = 1 + ($random(seed) & 15);
      evt(4'b1000, nr);
      evt(4'b0010, nt);
      evt(4'b1111, 3);
      evt(4'b0101, 1);
      rdchk(OFF_RX_PKT_COUNT, 1'b0, 32'(nr - 1));
      rdchk(OFF_TX_PKT_COUNT, 1'b0, 32'(nt - 1));
      wr(OFF_TX_PKT_COUNT, 32'h1fff);
      evt(4'b0010, 1);
      rdchk(OFF_TX_PKT_COUNT, 1'b0, 32'h0);
      // Window ends and both sides of the 20 KB point
      foreach (wins[i]) begin
         win_v[i] = $random(seed);
         wr(wins[i], win_v[i]);
         rdchk(wins[i], 1'b0, win_v[i]);
      end
      // Head pointer selects qword at byte offset pointer times 8
      for (int k = 0; k < 2; k++) begin
         // Stay clear of the quadwords that hold the window boundary data
         q = (k == 0) ? 13'h8 : 13'h600 + 13'({$random(seed)} % 1000);
         lo = $random(seed);
         hi = $random(seed);
         wr(WIN_BASE + (20'(q) << 3), lo);
         wr(WIN_BASE + (20'(q) << 3) + 20'h4, hi);
         wr(OFF_TX_HEAD, 32'(q));
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         chk(tx_head_data, {hi, lo});
      end
      // New size waits for the global reset
      wr(OFF_BUF_SIZE, 32'hffff_ff14);
      rdchk(OFF_BUF_SIZE, 1'b0, 32'h14);
      @(negedge pclk);
      chk(64'(buffer_size_active), 64'h28);
      devrst(6'h0a);
      chk(64'(buffer_size_active), 64'h14);
      rdchk(OFF_BUF_SIZE, 1'b0, 32'h14);
      rdchk(OFF_TX_HEAD_SAVED, 1'b0, 32'(tx_init(6'h0a)));
      rdchk(OFF_RX_HEAD_SAVED, 1'b0, 32'h0);
      rdchk(OFF_RX_PKT_COUNT, 1'b0, 32'h0);
      rdchk(wins[1], 1'b0, win_v[1]);
      apb(1'b1, wins[2], ~win_v[2], v, e);
      chk(64'(e), 64'h1);
      // Power-on returns the size to its default, memory kept
      por();
      rdchk(OFF_BUF_SIZE, 1'b0, 32'h28);
      @(negedge pclk);
      chk(64'(buffer_size_active), 64'h28);
      rdchk(wins[2], 1'b0, win_v[2]);
      rdchk(OFF_TX_TAIL, 1'b0, 32'(tx_init(6'h0a)));
      wrap_up();
   end

endmodule : tb

`default_nettype wire
